// ==== rtl/timer16_map.svh ====
// register map, field positions and constants of the sixteen-bit timer/counter
// Contract
// - count is two readable writable byte halves
// - count runs 0000h to FFFFh then wraps
// - wrap sets latched overflow flag bit 0
// - interrupt forwarded only while enable bit 0 set
// - control bit 1 selects timer or counter
// - timer mode counts instruction cycles after prescale
// - counter mode counts rising edges only
// - run enable bit 0 gates counting
// - capture/compare event trigger resets the count
// - oscillator enable forces pins input, read zero
// - prescale select divides by 1, 2, 4, 8
// - timer clock is oscillator over four, sync ignored
// - counter source is oscillator pin or clock pin
// - sync before prescaler; sleep freezes synchronised count only
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
// ----------------------------------------
// byte addresses
// ----------------------------------------
`define ADDR_COUNT_LOW 4'h0
`define ADDR_COUNT_HIGH 4'h1
`define ADDR_CONTROL 4'h2
`define ADDR_FLAG 4'h3
`define ADDR_ENABLE 4'h4
`define ADDR_PORT_DIR 4'h5
`define ADDR_PORT_IN 4'h6
// ----------------------------------------
// fields
// ----------------------------------------
`define CTL_RUN 0
`define CTL_CS 1
`define CTL_SYNC_DIS 2
`define CTL_OSC_EN 3
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_MASK 8'h3F
`define FLAG_OVF 0
`define RESET_BYTE 8'h00
`define RESET_DIR 2'h3
`define INSN_DIV 2'h3
`endif

// ==== rtl/timer16_pkg.sv ====
// types shared by the timer/counter files
package timer16_pkg;
    typedef struct packed {
        logic [1:0] prescale_select;
        logic oscillator_enable;
        logic sync_disable;
        logic clock_source_select;
        logic run_enable;
    } control_t;
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK,
        BUS_GAP
    } bus_state_t;
endpackage

// ==== rtl/timer16_prescaler.sv ====
// input prescaler for the timer/counter, divides increment pulses by 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none
module timer16_prescaler (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic clear_i,
    input wire logic [1:0] select_i,
    // pulses
    input wire logic tick_i,
    output logic tick_o
);
    logic [2:0] count;
    logic [2:0] limit;
    // 00 1:1, 01 1:2, 10 1:4, 11 1:8
    assign limit = (3'h1 << select_i) - 3'h1;
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            count <= 3'h0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (tick_i) begin
                if (count >= limit) begin
                    count <= 3'h0;
                    tick_o <= 1'b1;
                end else begin
                    count <= count + 3'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/timer16.sv ====
// sixteen-bit timer/counter with wishbone register access
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"
module timer16
    import timer16_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [7:0] dat_i,
    input wire logic sel_i,
    output logic [7:0] dat_o,
    output logic ack_o,
    // counting inputs
    input wire logic special_event_i,
    input wire logic sleep_i,
    input wire logic oscillator_input_pin_i,
    input wire logic external_clock_pin_i,
    // port pins shared with the oscillator
    output logic [1:0] port_oe_o,
    // interrupt
    output logic irq_o
);
    // ----------------------------------------
    // registers and synchronisers
    // ----------------------------------------
    control_t ctl;
    bus_state_t bus_state;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [1:0] port_direction_bits;
    logic [1:0] osc_meta;
    logic [1:0] osc_sync;
    logic [1:0] ext_meta;
    logic [1:0] ext_sync;
    logic src_last;
    logic [1:0] insn_div;
    logic insn_tick;
    logic src_level;
    logic edge_tick;
    logic raw_tick;
    logic ps_tick;
    logic inc;
    logic wrap;
    logic wr;
    logic rd_go;
    logic [7:0] next_dat;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_meta <= 2'h0;
            osc_sync <= 2'h0;
            ext_meta <= 2'h0;
            ext_sync <= 2'h0;
        end else begin
            osc_meta <= {osc_meta[0], oscillator_input_pin_i};
            ext_meta <= {ext_meta[0], external_clock_pin_i};
            osc_sync <= {osc_sync[0], osc_meta[1]};
            ext_sync <= {ext_sync[0], ext_meta[1]};
        end
    end

    // ----------------------------------------
    // clock source selection
    // ----------------------------------------
    // instruction cycle is four oscillator periods
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            insn_div <= 2'h0;
            insn_tick <= 1'b0;
        end else begin
            insn_div <= insn_div + 2'h1;
            insn_tick <= (insn_div == `INSN_DIV);
        end
    end

    // oscillator pin when the oscillator runs, clock pin otherwise
    assign src_level = ctl.oscillator_enable ? osc_sync[1] : ext_sync[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_last <= 1'b0;
        end else begin
            src_last <= src_level;
        end
    end

    assign edge_tick = src_level && !src_last;
    // mode select, sync control unused in timer mode
    assign raw_tick = ctl.clock_source_select ? edge_tick : insn_tick;

    // prescaler keeps running in sleep, so it only sees the run enable
    timer16_prescaler timer16_prescaler_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(wr && (adr_i == `ADDR_COUNT_LOW || adr_i == `ADDR_COUNT_HIGH)),
        .select_i(ctl.prescale_select),
        .tick_i(raw_tick && ctl.run_enable),
        .tick_o(ps_tick)
    );

    // synchronised counting freezes in sleep; async external counting goes on
    assign inc = ps_tick && ctl.run_enable &&
        !(sleep_i && !(ctl.clock_source_select && ctl.sync_disable));
    assign wrap = inc && ({count_high_byte, count_low_byte} == 16'hFFFF);

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    // writes land at the edge where the master sees ack, so an abandoned cycle changes nothing
    assign wr = (bus_state == BUS_ACK) && cyc_i && stb_i && we_i && sel_i;
    assign rd_go = (bus_state == BUS_IDLE) && cyc_i && stb_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state <= BUS_IDLE;
            ack_o <= 1'b0;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (rd_go) begin
                        bus_state <= BUS_ACK;
                        ack_o <= 1'b1;
                    end
                end
                BUS_ACK: begin
                    ack_o <= 1'b0;
                    bus_state <= BUS_GAP;
                end
                BUS_GAP: begin
                    if (!(cyc_i && stb_i)) begin
                        bus_state <= BUS_IDLE;
                    end
                end
                default: begin
                    bus_state <= BUS_IDLE;
                    ack_o <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        next_dat = `RESET_BYTE;
        case (adr_i)
            `ADDR_COUNT_LOW: next_dat = count_low_byte;
            `ADDR_COUNT_HIGH: next_dat = count_high_byte;
            `ADDR_CONTROL: next_dat = {2'h0, ctl} & `CTL_MASK;
            `ADDR_FLAG: next_dat = {7'h0, overflow_flag};
            `ADDR_ENABLE: next_dat = {7'h0, overflow_irq_enable};
            `ADDR_PORT_DIR: next_dat = {6'h0, port_direction_bits};
            // pins read as zero while the oscillator owns them
            `ADDR_PORT_IN: next_dat = ctl.oscillator_enable ? 8'h00 : {6'h0, osc_sync[1], ext_sync[1]};
            default: next_dat = `RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= `RESET_BYTE;
        end else if (rd_go) begin
            dat_o <= next_dat;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl <= control_t'(6'h00);
            overflow_irq_enable <= 1'b0;
            port_direction_bits <= `RESET_DIR;
        end else if (wr) begin
            if (adr_i == `ADDR_CONTROL) begin
                ctl <= control_t'(dat_i[5:0]);
            end
            if (adr_i == `ADDR_ENABLE) begin
                overflow_irq_enable <= dat_i[`FLAG_OVF];
            end
            if (adr_i == `ADDR_PORT_DIR) begin
                port_direction_bits <= dat_i[1:0];
            end
        end
    end

    // ----------------------------------------
    // count and overflow
    // ----------------------------------------
    // a byte write wins over an increment so software sees exactly what it wrote
    always_ff @(posedge clk_i) begin
        if (rst_i || special_event_i) begin
            count_low_byte <= `RESET_BYTE;
            count_high_byte <= `RESET_BYTE;
        end else if (wr && adr_i == `ADDR_COUNT_LOW) begin
            count_low_byte <= dat_i;
        end else if (wr && adr_i == `ADDR_COUNT_HIGH) begin
            count_high_byte <= dat_i;
        end else if (inc) begin
            {count_high_byte, count_low_byte} <= {count_high_byte, count_low_byte} + 16'h0001;
        end
    end

    // set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (wr && adr_i == `ADDR_FLAG && dat_i[`FLAG_OVF]) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            port_oe_o <= 2'h0;
        end else begin
            irq_o <= (overflow_flag || wrap) && overflow_irq_enable;
            // direction bit 1 means input, as on the port
            port_oe_o <= ctl.oscillator_enable ? 2'h0 : ~port_direction_bits;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_wrap_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap |=> overflow_flag)
        else $error("overflow flag not set after wrap");
    a_wrap_to_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (wrap && !wr && !special_event_i) |=> ({count_high_byte, count_low_byte} == 16'h0000))
        else $error("count did not wrap to zero");
    a_hold_when_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctl.run_enable && !wr && !special_event_i) |=> $stable({count_high_byte, count_low_byte}))
        else $error("count moved while stopped");
    a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> $past(overflow_irq_enable))
        else $error("interrupt without enable");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (overflow_flag && !(wr && adr_i == `ADDR_FLAG)) |=> overflow_flag)
        else $error("overflow flag lost");
    a_event_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        special_event_i |=> ({count_high_byte, count_low_byte} == 16'h0000))
        else $error("special event did not reset count");
    a_osc_pins_in: assert property (@(posedge clk_i) disable iff (rst_i)
        ctl.oscillator_enable |=> (port_oe_o == 2'h0))
        else $error("oscillator pins driven");
    a_rise_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctl.clock_source_select && raw_tick) |-> (src_level && !src_last))
        else $error("counted a non-rising edge");
    a_timer_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctl.clock_source_select && raw_tick) |=> !raw_tick [*3])
        else $error("timer tick faster than one per four clocks");
endmodule
`default_nettype wire

// ==== test/edge_source.sv ====
// pulse source standing in for the external clock or crystal at the counting pins
`timescale 1ns/10ps
`default_nettype none
module edge_source (
    // clock
    input wire logic clk_i,
    // request
    input wire logic start_i,
    input wire logic [7:0] pulses_i,
    input wire logic to_osc_i,
    // pins
    output logic ext_pin_o,
    output logic osc_pin_o,
    output logic busy_o
);
    logic [7:0] left = 8'h00;
    logic [2:0] phase = 3'h0;
    logic level = 1'b0;
    // half period of four clocks, slow enough for a four-flop synchroniser
    always @(posedge clk_i) begin
        if (start_i) begin
            left <= pulses_i;
            phase <= 3'h0;
        end else if (left != 8'h00) begin
            phase <= phase + 3'h1;
            if (phase[1:0] == 2'h3) begin
                level <= ~level;
                if (level) begin
                    left <= left - 8'h01;
                end
            end
        end
    end
    // the unselected pin and an idle source stand still low
    assign ext_pin_o = level & ~to_osc_i;
    assign osc_pin_o = level & to_osc_i;
    assign busy_o = (left != 8'h00);
endmodule
`default_nettype wire

// ==== test/sixteen_bit_timer_counter_test.sv ====
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/10ps
`default_nettype none
`include "timer16_map.svh"
module sixteen_bit_timer_counter_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b1, sev = 1'b0, slp = 1'b0;
    logic start = 1'b0, to_osc = 1'b0;
    logic [7:0] pulses = 8'h00, dat = 8'h00, dat_o, rd;
    logic [3:0] adr = 4'h0;
    logic ack_o, irq_o, ext_pin, osc_pin, busy;
    logic [1:0] port_oe_o;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    timer16 timer16_inst (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(dat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o), .special_event_i(sev), .sleep_i(slp),
        .oscillator_input_pin_i(osc_pin), .external_clock_pin_i(ext_pin), .port_oe_o(port_oe_o), .irq_o(irq_o));
    edge_source edge_source_inst (.clk_i(clk), .start_i(start), .pulses_i(pulses), .to_osc_i(to_osc),
        .ext_pin_o(ext_pin), .osc_pin_o(osc_pin), .busy_o(busy));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task conclude;
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task check_range(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("Error %s expected %h to %h seen %h", what, lo, hi, got);
        end
    endtask
    // one classic cycle; the gap before the next comes from the leading edge wait
    task bus(input logic w, input logic s, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack_o !== 1'b1) @(posedge clk);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b1, a, d);
    endtask
    task rdb(input logic [3:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task pulse(input logic [7:0] n, input logic o);
        @(posedge clk);
        start <= 1'b1;
        pulses <= n;
        to_osc <= o;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        rdb(`ADDR_COUNT_LOW);
        check_val("count low", 8'h00, rd);
        check_val("port oe", 8'h00, {6'h00, port_oe_o});
        check_val("irq", 8'h00, {7'h00, irq_o});
        rdb(4'h7);
        check_val("unmapped", 8'h00, rd);
        wr(`ADDR_COUNT_LOW, 8'hA5);
        wr(`ADDR_COUNT_HIGH, 8'h5A);
        rdb(`ADDR_COUNT_LOW);
        check_val("count low", 8'hA5, rd);
        rdb(`ADDR_COUNT_HIGH);
        check_val("count high", 8'h5A, rd);
        bus(1'b1, 1'b0, `ADDR_COUNT_HIGH, 8'h77);
        rdb(`ADDR_COUNT_HIGH);
        check_val("unselected write", 8'h5A, rd);
    endtask
    task t_prescale;
        for (int p = 0; p < 4; p++) begin
            wr(`ADDR_COUNT_LOW, 8'h00);
            wr(`ADDR_COUNT_HIGH, 8'h00);
            wr(`ADDR_CONTROL, {2'h0, p[1:0], 4'h1});
            repeat (40 << p) @(posedge clk);
            wr(`ADDR_CONTROL, 8'h00);
            rdb(`ADDR_COUNT_LOW);
            check_range("timer count", 8'h09, 8'h0B, rd);
        end
    endtask
    task t_hold;
        wr(`ADDR_COUNT_LOW, 8'h00);
        slp <= 1'b1;
        wr(`ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge clk);
        rdb(`ADDR_COUNT_LOW);
        check_val("sleep count", 8'h00, rd);
        wr(`ADDR_CONTROL, 8'h00);
        slp <= 1'b0;
        repeat (40) @(posedge clk);
        rdb(`ADDR_COUNT_LOW);
        check_val("stopped count", 8'h00, rd);
    endtask
    task t_wrap;
        wr(`ADDR_ENABLE, 8'h01);
        wr(`ADDR_FLAG, 8'h01);
        wr(`ADDR_COUNT_HIGH, 8'hFF);
        wr(`ADDR_COUNT_LOW, 8'hFF);
        wr(`ADDR_CONTROL, 8'h01);
        while (irq_o !== 1'b1) @(posedge clk);
        wr(`ADDR_CONTROL, 8'h00);
        rdb(`ADDR_FLAG);
        check_val("flag", 8'h01, rd);
        rdb(`ADDR_COUNT_HIGH);
        check_val("wrapped high", 8'h00, rd);
        wr(`ADDR_ENABLE, 8'h00);
        repeat (2) @(posedge clk);
        check_val("masked irq", 8'h00, {7'h00, irq_o});
        rdb(`ADDR_FLAG);
        check_val("held flag", 8'h01, rd);
        wr(`ADDR_ENABLE, 8'h01);
        repeat (2) @(posedge clk);
        check_val("unmasked irq", 8'h01, {7'h00, irq_o});
        wr(`ADDR_FLAG, 8'h01);
        repeat (2) @(posedge clk);
        check_val("cleared irq", 8'h00, {7'h00, irq_o});
    endtask
    task t_counter;
        wr(`ADDR_COUNT_LOW, 8'h00);
        wr(`ADDR_CONTROL, 8'h03);
        pulse(8'h05, 1'b0);
        rdb(`ADDR_COUNT_LOW);
        check_val("edges", 8'h05, rd);
        wr(`ADDR_PORT_DIR, 8'h00);
        repeat (2) @(posedge clk);
        check_val("port oe", 8'h03, {6'h00, port_oe_o});
        wr(`ADDR_CONTROL, 8'h0B);
        repeat (2) @(posedge clk);
        check_val("osc port oe", 8'h00, {6'h00, port_oe_o});
        pulse(8'h03, 1'b0);
        pulse(8'h03, 1'b1);
        rdb(`ADDR_COUNT_LOW);
        check_val("osc edges", 8'h08, rd);
        sev <= 1'b1;
        @(posedge clk);
        sev <= 1'b0;
        rdb(`ADDR_COUNT_LOW);
        check_val("event clear", 8'h00, rd);
    endtask
    // pin reads follow the clock pin, and stay zero while the oscillator owns the pins
    task t_pins;
        logic seen;
        seen = 1'b0;
        wr(`ADDR_CONTROL, 8'h00);
        @(posedge clk);
        start <= 1'b1;
        pulses <= 8'h04;
        to_osc <= 1'b0;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        while (busy) begin
            rdb(`ADDR_PORT_IN);
            seen = seen | rd[0];
        end
        check_val("clock pin read", 8'h01, {7'h00, seen});
        wr(`ADDR_CONTROL, 8'h08);
        @(posedge clk);
        start <= 1'b1;
        to_osc <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        while (busy) begin
            rdb(`ADDR_PORT_IN);
            check_val("oscillator pin read", 8'h00, rd);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_prescale();
        t_hold();
        t_wrap();
        t_pins();
        t_counter();
        conclude();
    end
endmodule
`default_nettype wire
